// >>> common/lpm_defines.vh
// Purpose: Constants of the low-power mode controller
// Assumes: 20 MHz reference clock
// Notes:   Definitions only
`ifndef LPM_DEFINES_VH
`define LPM_DEFINES_VH

// Mode select encodings
`define MODE_WAIT       3'h0
`define MODE_AHALT_RON  3'h1
`define MODE_AHALT_ROFF 3'h2
`define MODE_HALT       3'h3

// Timing
`define CLK_MHZ          32'h00000014
`define REG_SETTLE_US    32'h0000000a
`define REG_SETTLE_CYC   (`REG_SETTLE_US * `CLK_MHZ)
`define CLK_RESTORE_CYC  16'h0004
`define WKUP_PERIOD_RST  16'h0100
`endif

// >>> design/low_power_mode_controller.v
// Purpose: Low-power mode controller: clock gating, regulator control, wakeup
// Assumes: All inputs synchronous to REF_CLK_I; reset comes from the system
// Notes:
// Function
// - Four software-selectable modes: wait, active-halt reg on/off, halt.
// - Wait stops the core clock, peripheral clocks keep running.
// - Wait ends on internal interrupt, external interrupt or reset.
// - Both active-halt variants gate core and all peripheral clocks.
// - Periodic wakeup unit keeps counting in active-halt, programmable interval.
// - Active-halt regulator on keeps the main regulator enabled.
// - Active-halt ends on periodic wakeup, external interrupt or reset.
// - Active-halt regulator off disables the main regulator, longer wakeup.
// - Halt stops all clocks, regulator off, wakes on external event or reset.
// - Clock reaches only modules selected for the mode; logic stays powered.
// - RAM retention and brown-out detection stay active in every mode.
`timescale 1ns/1ns
`include "lpm_defines.vh"
module low_power_mode_controller #(
    parameter WK_WIDTH   = 16,
    parameter REG_SETTLE = `REG_SETTLE_CYC
) (
    input  wire                REF_CLK_I,
    input  wire                RST_N_I,
    input  wire                ENTER_I,        // Pulse from core: enter selected mode
    input  wire [2:0]          MODE_SEL_I,
    input  wire [WK_WIDTH-1:0] WKUP_PERIOD_I,
    input  wire                INT_IRQ_I,      // Any internal peripheral interrupt
    input  wire                EXT_IRQ_I,      // Any external interrupt or event
    output reg                 CPU_CLK_EN_O,
    output reg                 PER_CLK_EN_O,
    output reg                 WKUP_CLK_EN_O,
    output reg                 REG_EN_O,
    output reg                 RAM_RETAIN_O,
    output reg                 BOR_EN_O,
    output reg                 FETCH_EN_O,
    output reg                 WKUP_EVENT_O,
    output reg  [2:0]          STATE_O
);
    // ****************************************************************
    // State codes
    // ****************************************************************
    // Both active-halt modes park in ST_AHALT, so STATE_O does not show
    // which regulator setting was selected while the device sleeps
    localparam [2:0] ST_RUN    = 3'b000;
    localparam [2:0] ST_WAIT   = 3'b001;
    localparam [2:0] ST_AHALT  = 3'b010;
    localparam [2:0] ST_HALT   = 3'b011;
    localparam [2:0] ST_REG_UP = 3'b100;
    localparam [2:0] ST_CLK_UP = 3'b101;

    // Last count of each restore phase; the settle count is cut to the
    // counter width on purpose, so it must stay below 65536 cycles
    localparam [31:0] SETTLE_FULL  = REG_SETTLE;
    localparam [15:0] SETTLE_LAST  = SETTLE_FULL[15:0] - 16'h0001;
    localparam [15:0] RESTORE_LAST = `CLK_RESTORE_CYC - 16'h0001;

    // ****************************************************************
    // State, counters and the periodic wakeup unit
    // ****************************************************************
    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg         roff_reg;      // Regulator was switched off on entry
    reg         roff_next;
    reg  [15:0] cnt_reg;       // Restore phase counter
    reg  [15:0] cnt_next;
    reg         cpu_clk_next;
    reg         per_clk_next;
    reg         wkup_clk_next;
    reg         reg_en_next;
    reg         fetch_next;
    reg         event_next;
    wire        wake_tick;     // One-cycle request from the periodic unit
    wire        wake_run;      // Periodic unit counts only in active-halt

    // Held cleared outside active-halt, so every stay starts a full interval
    assign wake_run = (state_reg == ST_AHALT);

    periodic_wakeup_unit #(.WIDTH(WK_WIDTH)) u_wake_unit (
        .clk_i    (REF_CLK_I),
        .rst_n_i  (RST_N_I),
        .run_i    (wake_run),
        .period_i (WKUP_PERIOD_I),
        .wake_o   (wake_tick)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Unknown mode codes and requests outside run are ignored, so a stray
    // request cannot park the core in a state it has no way out of
    always @* begin
        state_next = state_reg;
        roff_next  = roff_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            ST_RUN: begin
                if (ENTER_I) begin
                    case (MODE_SEL_I)
                        `MODE_WAIT: begin
                            state_next = ST_WAIT;
                            roff_next  = 1'b0;
                        end
                        `MODE_AHALT_RON: begin
                            state_next = ST_AHALT;
                            roff_next  = 1'b0;
                        end
                        `MODE_AHALT_ROFF: begin
                            state_next = ST_AHALT;
                            roff_next  = 1'b1;
                        end
                        `MODE_HALT: begin
                            state_next = ST_HALT;
                            roff_next  = 1'b1;
                        end
                        default: begin
                            state_next = ST_RUN;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                // The regulator stays on in wait, so only clocks need restoring
                if (INT_IRQ_I || EXT_IRQ_I) begin
                    state_next = ST_CLK_UP;
                    cnt_next   = 16'h0000;
                end
            end
            ST_AHALT: begin
                // Internal interrupts are ignored: their sources are unclocked here
                if (EXT_IRQ_I || wake_tick) begin
                    state_next = roff_reg ? ST_REG_UP : ST_CLK_UP;
                    cnt_next   = 16'h0000;
                end
            end
            ST_HALT: begin
                // The periodic unit has no clock here; only an external event wakes
                if (EXT_IRQ_I) begin
                    state_next = ST_REG_UP;
                    cnt_next   = 16'h0000;
                end
            end
            ST_REG_UP: begin
                // Core and peripheral clocks stay off until the regulator has settled; the wakeup clock runs
                if (cnt_reg >= SETTLE_LAST) begin
                    state_next = ST_CLK_UP;
                    roff_next  = 1'b0;
                    cnt_next   = 16'h0000;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
            ST_CLK_UP: begin
                // Fetch waits a few cycles while the clock trees restart
                if (cnt_reg >= RESTORE_LAST) begin
                    state_next = ST_RUN;
                    cnt_next   = 16'h0000;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    // Reset is a wakeup source for every mode: it forces run directly
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= ST_RUN;
            roff_reg  <= 1'b0;
            cnt_reg   <= 16'h0000;
        end else begin
            state_reg <= state_next;
            roff_reg  <= roff_next;
            cnt_reg   <= cnt_next;
        end
    end

    // ****************************************************************
    // Output decode
    // ****************************************************************
    // Decoded from the next state so the registered enables line up with
    // state_reg; this costs one level of logic ahead of the output flops
    always @* begin
        cpu_clk_next  = (state_next == ST_RUN) || (state_next == ST_CLK_UP);
        per_clk_next  = (state_next == ST_RUN) || (state_next == ST_WAIT)
                        || (state_next == ST_CLK_UP);
        wkup_clk_next = (state_next != ST_HALT);
        reg_en_next   = !(roff_next && ((state_next == ST_AHALT)
                          || (state_next == ST_HALT)));
        fetch_next    = (state_next == ST_RUN);
        // A stay in a low-power state ends whenever the state moves on
        event_next    = ((state_reg == ST_WAIT) || (state_reg == ST_AHALT)
                         || (state_reg == ST_HALT)) && (state_next != state_reg);
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    // Retention and brown-out detection are never switched off by a mode
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CPU_CLK_EN_O  <= 1'b1;
            PER_CLK_EN_O  <= 1'b1;
            WKUP_CLK_EN_O <= 1'b1;
            REG_EN_O      <= 1'b1;
            RAM_RETAIN_O  <= 1'b1;
            BOR_EN_O      <= 1'b1;
            FETCH_EN_O    <= 1'b1;
            WKUP_EVENT_O  <= 1'b0;
            STATE_O       <= ST_RUN;
        end else begin
            CPU_CLK_EN_O  <= cpu_clk_next;
            PER_CLK_EN_O  <= per_clk_next;
            WKUP_CLK_EN_O <= wkup_clk_next;
            REG_EN_O      <= reg_en_next;
            RAM_RETAIN_O  <= 1'b1;
            BOR_EN_O      <= 1'b1;
            FETCH_EN_O    <= fetch_next;
            WKUP_EVENT_O  <= event_next;
            STATE_O       <= state_next;
        end
    end
endmodule // low_power_mode_controller

// >>> design/periodic_wakeup_unit.v
// Purpose: Periodic wakeup counter, counts while enabled
// Assumes: One clock, enable level driven by the controller
// Notes:   Raises a one-cycle request every period+1 counts
`timescale 1ns/1ns
module periodic_wakeup_unit #(
    parameter WIDTH = 16
) (
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             run_i,
    input  wire [WIDTH-1:0] period_i,
    output reg              wake_o
);
    reg [WIDTH-1:0] count_reg;

    // Count up to period, then pulse and restart
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= {WIDTH{1'b0}};
            wake_o    <= 1'b0;
        end else if (!run_i) begin
            count_reg <= {WIDTH{1'b0}};
            wake_o    <= 1'b0;
        end else if (count_reg >= period_i) begin
            count_reg <= {WIDTH{1'b0}};
            wake_o    <= 1'b1;
        end else begin
            count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
            wake_o    <= 1'b0;
        end
    end
endmodule // periodic_wakeup_unit

// >>> tb/low_power_mode_controller_tb_top.sv
// Purpose: Directed bench for the low-power mode controller
// Assumes: Short regulator settle count for run time
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ns
module low_power_mode_controller_tb_top;
    // ****************************************************************
    // Bench signals
    // ****************************************************************
    // A short settle count keeps the regulator restore within a few cycles
    localparam int RS = 32'h00000004;
    logic        clk          = 1'b0;
    logic        rst_n        = 1'b0;
    logic        enter        = 1'b0;
    logic        irq_i        = 1'b0;
    logic        irq_e        = 1'b0;
    logic [2:0]  mode         = 3'h0;
    logic [15:0] period       = 16'h0003;
    wire         cpu;
    wire         per;
    wire         wck;
    wire         reg_en;
    wire         ram;
    wire         bor;
    wire         fetch;
    wire         wev;
    wire  [2:0]  st;
    int          n_errors     = 0;
    int          total_checks = 0;

    low_power_mode_controller #(.REG_SETTLE(RS)) i_dut (
        .REF_CLK_I     (clk),
        .RST_N_I       (rst_n),
        .ENTER_I       (enter),
        .MODE_SEL_I    (mode),
        .WKUP_PERIOD_I (period),
        .INT_IRQ_I     (irq_i),
        .EXT_IRQ_I     (irq_e),
        .CPU_CLK_EN_O  (cpu),
        .PER_CLK_EN_O  (per),
        .WKUP_CLK_EN_O (wck),
        .REG_EN_O      (reg_en),
        .RAM_RETAIN_O  (ram),
        .BOR_EN_O      (bor),
        .FETCH_EN_O    (fetch),
        .WKUP_EVENT_O  (wev),
        .STATE_O       (st)
    );

    // 20 MHz reference clock
    initial begin
        forever begin
            #25 clk = ~clk;
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task chk(input logic [7:0] s, input logic [7:0] e, input string nm);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    task nc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Hold the request across exactly one rising edge
    task go(input logic [2:0] m);
        mode  = m;
        enter = 1'b1;
        nc(1);
        enter = 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Wait, a refused request inside it, interrupt exit, invalid mode code
    task t_wait;
        go(3'h0);
        chk({st, cpu, per, reg_en}, {3'h1, 3'b011}, "wait");
        nc(1);
        go(3'h3);
        chk(st, 3'h1, "enter refused");
        irq_i = 1'b1;
        nc(1);
        irq_i = 1'b0;
        chk({st, wev}, {3'h5, 1'b1}, "wake");
        nc(1);
        chk({st, wev, fetch}, {3'h5, 2'b00}, "event pulse");
        nc(3);
        chk({st, fetch}, {3'h0, 1'b1}, "run");
        go(3'h4);
        chk({st, cpu, fetch}, {3'h0, 2'b11}, "bad mode");
        nc(1);
        $display("wait test done");
    endtask

    // Period 3 gives a request after four counting edges, the move one later
    task t_ahalt_on;
        go(3'h1);
        chk({st, cpu, per, reg_en, wck}, {3'h2, 4'b0011}, "ahon");
        irq_i = 1'b1;
        nc(1);
        irq_i = 1'b0;
        chk(st, 3'h2, "int ignored");
        nc(3);
        chk(st, 3'h2, "before wake");
        nc(1);
        chk({st, wev}, {3'h5, 1'b1}, "periodic wake");
        nc(4);
        chk({st, fetch}, {3'h0, 1'b1}, "ahon run");
        $display("ahalt on test done");
    endtask

    // Regulator comes back first, clocks follow after the settle count
    task t_ahalt_off;
        go(3'h2);
        chk({st, cpu, per, reg_en}, {3'h2, 3'b000}, "ahoff");
        irq_e = 1'b1;
        nc(1);
        irq_e = 1'b0;
        chk({st, reg_en, cpu, wev}, {3'h4, 3'b101}, "reg up");
        nc(RS - 1);
        chk({st, reg_en, cpu}, {3'h4, 2'b10}, "reg settling");
        nc(1);
        chk({st, cpu, per, fetch}, {3'h5, 3'b110}, "clk up");
        nc(4);
        chk({st, fetch}, {3'h0, 1'b1}, "fetch");
        $display("ahalt off test done");
    endtask

    // Halt ignores the internal interrupt, then a reset cuts the wakeup
    task t_halt;
        go(3'h3);
        irq_i = 1'b1;
        nc(12);
        irq_i = 1'b0;
        chk({st, reg_en, wck, ram, bor}, {3'h3, 4'b0011}, "halt");
        irq_e = 1'b1;
        nc(1);
        irq_e = 1'b0;
        chk({st, reg_en}, {3'h4, 1'b1}, "halt wake");
        rst_n = 1'b0;
        nc(1);
        chk({st, cpu, per, reg_en}, {3'h0, 3'b111}, "reset");
        rst_n = 1'b1;
        nc(1);
        go(3'h0);
        chk(st, 3'h1, "entry after reset");
        $display("halt test done");
    endtask

    // ****************************************************************
    // Verdict
    // ****************************************************************
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if ((n_errors == 0) && (total_checks > 0)) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The tests need about 60 cycles; the limit leaves ample margin
    initial begin
        repeat (2000) @(posedge clk);
        n_errors++;
        wrap_up;
    end

    initial begin
        nc(12);
        rst_n = 1'b1;
        nc(1);
        t_wait;
        t_ahalt_on;
        t_ahalt_off;
        t_halt;
        wrap_up;
    end
endmodule // low_power_mode_controller_tb_top

// >>> tb/lpm_checker.sv
// Purpose: Port assertions for the low-power mode controller
// Assumes: One clock domain, active-low asynchronous reset
// Notes:   Bound to every controller instance
`timescale 1ns/1ns
module lpm_checker #(
    parameter REG_SETTLE = 200
) (
    input wire       REF_CLK_I,
    input wire       RST_N_I,
    input wire       ENTER_I,
    input wire [2:0] MODE_SEL_I,
    input wire       INT_IRQ_I,
    input wire       EXT_IRQ_I,
    input wire       CPU_CLK_EN_O,
    input wire       PER_CLK_EN_O,
    input wire       WKUP_CLK_EN_O,
    input wire       REG_EN_O,
    input wire       RAM_RETAIN_O,
    input wire       BOR_EN_O,
    input wire       FETCH_EN_O,
    input wire       WKUP_EVENT_O,
    input wire [2:0] STATE_O
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    // A request only counts when it meets the run state
    wire go = (STATE_O == 3'h0) && ENTER_I;

    wait_entry_a: assert property (go && (MODE_SEL_I == 3'h0) |=>
        (STATE_O == 3'h1) && !CPU_CLK_EN_O && PER_CLK_EN_O)
        else $error("wait entry wrong");
    ahalt_on_a: assert property (go && (MODE_SEL_I == 3'h1) |=>
        (STATE_O == 3'h2) && !CPU_CLK_EN_O && !PER_CLK_EN_O && REG_EN_O)
        else $error("active halt on entry wrong");
    ahalt_off_a: assert property (go && (MODE_SEL_I == 3'h2) |=>
        (STATE_O == 3'h2) && !REG_EN_O && !PER_CLK_EN_O)
        else $error("active halt off entry wrong");
    halt_entry_a: assert property (go && (MODE_SEL_I == 3'h3) |=>
        (STATE_O == 3'h3) && !REG_EN_O && !WKUP_CLK_EN_O)
        else $error("halt entry wrong");
    // The wakeup flag rises in the same cycle the restore starts
    wait_wake_a: assert property ((STATE_O == 3'h1) && (INT_IRQ_I || EXT_IRQ_I) |=>
        (STATE_O == 3'h5) && WKUP_EVENT_O)
        else $error("wait wakeup wrong");
    halt_hold_a: assert property ((STATE_O == 3'h3) && !EXT_IRQ_I |=> $stable(STATE_O))
        else $error("halt left without event");
    ahalt_wake_a: assert property ((STATE_O == 3'h2) && EXT_IRQ_I |=>
        STATE_O inside {3'h4, 3'h5})
        else $error("active halt wakeup wrong");
    reg_first_a: assert property ((STATE_O == 3'h4) |->
        REG_EN_O && !CPU_CLK_EN_O && !FETCH_EN_O)
        else $error("regulator restore order wrong");
    keep_alive_a: assert property (RAM_RETAIN_O && BOR_EN_O)
        else $error("retention dropped");

    // Main scenarios: active-halt entry to wakeup, regulator restore, wait exit
    cover property (go ##1 (STATE_O == 3'h2) ##[1:40] (STATE_O == 3'h5));
    cover property ((STATE_O == 3'h4) ##[1:300] FETCH_EN_O);
    cover property ((STATE_O == 3'h1) ##1 WKUP_EVENT_O);
endmodule // lpm_checker
bind low_power_mode_controller lpm_checker #(.REG_SETTLE(REG_SETTLE)) i_chk (.*);
